/* File: common/dsw_pkg.sv */
package dsw_pkg;

	// ----------------------------------------------------------------
	// sizes and clock
	// ----------------------------------------------------------------
	localparam int          NCH        = 4;
	localparam int          CODE_W     = 12;
	localparam int unsigned CLK_MHZ    = 40;
	localparam int unsigned TIMEOUT_US = 25000;
	localparam int unsigned TIMEOUT_CYC_DEF = TIMEOUT_US * CLK_MHZ;
	localparam int unsigned SCL_PERIOD_NS = 2500;
	localparam int unsigned SCL_QTR_CYC   = SCL_PERIOD_NS * CLK_MHZ / 1000 / 4;

	// ----------------------------------------------------------------
	// link command codes and operation values
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_PAGE  = 8'h00;
	localparam logic [7:0] CMD_OPER  = 8'h01;
	localparam logic [7:0] CMD_FAULT = 8'h7e;
	localparam logic [7:0] CMD_REV   = 8'h98;
	localparam logic [7:0] CMD_FCFG  = 8'hd0;
	localparam logic [7:0] CMD_MHI   = 8'hd1;
	localparam logic [7:0] CMD_MLO   = 8'hd2;
	localparam logic [7:0] CMD_IFCFG = 8'hd3;
	localparam logic [7:0] OP_OFF    = 8'h00;
	localparam logic [7:0] OP_ON     = 8'h80;
	localparam logic [7:0] OP_MLO    = 8'h98;
	localparam logic [7:0] OP_MHI    = 8'ha8;
	localparam logic [7:0] PMB_REV   = 8'h22;

	// ----------------------------------------------------------------
	// field layouts and reset values
	// ----------------------------------------------------------------
	localparam int FC_SLEW_LSB  = 0;
	localparam int FC_STEP_LSB  = 4;
	localparam int FC_WAVE_LSB  = 8;
	localparam int FC_FUNC_BIT  = 11;
	localparam int FAULT_BIT    = 1;
	localparam int IFCFG_EN_BIT = 0;
	localparam logic [2:0] WAVE_TRI  = 3'h0;
	localparam logic [2:0] WAVE_SAW  = 3'h1;
	localparam logic [2:0] WAVE_ISAW = 3'h2;
	localparam logic [2:0] WAVE_SINE = 3'h4;
	localparam logic [7:0]        RST_OP   = OP_OFF;
	localparam logic [15:0]       RST_FCFG = 16'h0000;
	localparam logic [CODE_W-1:0] RST_MHI  = 12'hfff;
	localparam logic [CODE_W-1:0] RST_MLO  = 12'h000;
	localparam int SINE_LEN = 24;

	localparam logic [5:0] STEP_LSB [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10, 6'h20};
	localparam int unsigned SLEW_NS [16] = '{0, 4000, 8000, 12000, 18000, 27040, 40480, 60720,
		91120, 136720, 239200, 418640, 732560, 1282000, 2563960, 5127920};
	localparam logic [11:0] SINE_TAB [SINE_LEN] = '{12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f,
		12'he66, 12'he2f, 12'hd8b, 12'hc87, 12'hb33, 12'h9a8, 12'h800, 12'h658, 12'h4cd, 12'h379,
		12'h275, 12'h1d1, 12'h19a, 12'h1d1, 12'h275, 12'h379, 12'h4cd, 12'h658};

	// ----------------------------------------------------------------
	// host register map
	// ----------------------------------------------------------------
	localparam logic [3:0] AV_CTRL  = 4'h0;
	localparam logic [3:0] AV_WDATA = 4'h4;
	localparam logic [3:0] AV_RDATA = 4'h8;
	localparam logic [3:0] AV_STAT  = 4'hc;
	localparam int CT_ADDR_LSB = 0;
	localparam int CT_CMD_LSB  = 8;
	localparam int CT_NB_LSB   = 16;
	localparam int CT_RD_BIT   = 20;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_NACK_BIT = 1;

	typedef enum logic [4:0] {
		DP_IDLE = 5'b00001,
		DP_ADDR = 5'b00010,
		DP_CMD  = 5'b00100,
		DP_WR   = 5'b01000,
		DP_RD   = 5'b10000
	} dsw_dph_t;

	typedef enum logic [3:0] {
		HP_IDLE  = 4'b0001,
		HP_START = 4'b0010,
		HP_BYTE  = 4'b0100,
		HP_STOP  = 4'b1000
	} dsw_hph_t;

endpackage: dsw_pkg

/* File: common/dsw_link_if.sv */
`timescale 1ns/1ps
interface dsw_link_if;
	logic scl;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic sda;

	// open-drain data line: low while either end drives
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport host (output scl, output host_sda_oe, input sda);
	modport dev (input scl, input sda, output dev_sda_oe);
endinterface: dsw_link_if

/* File: verilog/dsw_dev.sv */
// Behaviour
// - four-bit selector sets step period, zero no slew
// - each channel runs its own generator
// - waveform 000 gives triangle between limits
// - triangle takes ceil(diff/step) steps each way
// - waveform 001 gives rising sawtooth, restart low
// - waveform 010 gives falling sawtooth, restart high
// - sawtooth period is ceil(diff/step)+1 steps
// - sine steps 24 table codes, one per period
// - protocol commands other than interface config only while enable bit set
// - off, on, margin low/high, fault, revision
// - controller sends address+write, then command byte
// - write data assembled least significant byte first
// - read data returned least significant byte first
// - operation uses limits, period and step size
// - controller selects page before channel command
// - group commands supported; timeout is comm fault
// - fault flag set on fault, cleared by 1
// - read-only revision register reports protocol revision
// - three-bit selector gives 1..32 LSB step
// - margin command slews from present code to limit
// - waveform 100 selects sine generation
`timescale 1ns/1ps
module dsw_dev
	import dsw_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR    = 7'h4a,           // target address
	parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYC_DEF, // clock-low timeout
	parameter int unsigned TIME_SCALE  = 1                // divides step periods in simulation
)(
	input  wire logic                         CLOCK_IN,   // 40 MHz clock
	input  wire logic                         RST_IN,     // sync reset, active high
	dsw_link_if.dev                           LINK,       // two-wire link
	output logic      [NCH-1:0][CODE_W-1:0]   CODE_OUT,   // per-channel output code
	output logic      [NCH-1:0]               OUT_EN_OUT, // channel turned on
	output logic                              FAULT_OUT   // communication fault flag
);

	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	typedef struct packed {
		logic [2:0]                   scl_s;
		logic [2:0]                   sda_s;
		dsw_dph_t                     ph;
		logic [3:0]                   bitn;
		logic                         ackph;
		logic [7:0]                   sh;
		logic [7:0]                   cmd;
		logic [1:0]                   bidx;
		logic [15:0]                  wbuf;
		logic                         pend;
		logic                         sda_oe;
		logic                         fault;
		logic                         en;
		logic [TW-1:0]                tmo;
		logic [1:0]                   page;
		logic [NCH-1:0][7:0]          op;
		logic [NCH-1:0][15:0]         fcfg;
		logic [NCH-1:0][CODE_W-1:0]   mhi;
		logic [NCH-1:0][CODE_W-1:0]   mlo;
		logic [NCH-1:0][CODE_W-1:0]   code;
		logic [NCH-1:0][17:0]         cnt;
		logic [NCH-1:0]               up;
		logic [NCH-1:0]               oen;
		logic [NCH-1:0][4:0]          sidx;
	} dsw_dev_st_t;

	dsw_dev_st_t st_r;
	dsw_dev_st_t st_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [17:0] per_cyc(input logic [3:0] s);
		int unsigned c;
		c = SLEW_NS[s] * CLK_MHZ / 1000 / TIME_SCALE;
		if (c < 1)
			c = 1;
		per_cyc = 18'(c - 1);
	endfunction: per_cyc

	function automatic logic [CODE_W-1:0] step_up(input logic [CODE_W-1:0] c, input logic [5:0] s,
		input logic [CODE_W-1:0] lim);
		logic [CODE_W:0] u;
		u = {1'b0, c} + {{(CODE_W-5){1'b0}}, s};
		step_up = (u >= {1'b0, lim}) ? lim : u[CODE_W-1:0];
	endfunction: step_up

	function automatic logic [CODE_W-1:0] step_dn(input logic [CODE_W-1:0] c, input logic [5:0] s,
		input logic [CODE_W-1:0] lim);
		if ({1'b0, c} <= {1'b0, lim} + {{(CODE_W-5){1'b0}}, s})
			step_dn = lim;
		else
			step_dn = c - {{(CODE_W-6){1'b0}}, s};
	endfunction: step_dn

	function automatic logic known(input logic [7:0] c);
		known = (c == CMD_PAGE) || (c == CMD_OPER) || (c == CMD_FAULT) || (c == CMD_REV) ||
			(c == CMD_FCFG) || (c == CMD_MHI) || (c == CMD_MLO) || (c == CMD_IFCFG);
	endfunction: known

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic              scl_rise;
		logic              scl_fall;
		logic              start_ev;
		logic              stop_ev;
		logic              fault_set;
		logic              fault_clr;
		logic [15:0]       rdw;
		logic [7:0]        rdb;
		logic [3:0]        slew;
		logic [5:0]        stp;
		logic [CODE_W-1:0] nc;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_ev = 1'b0;
		stop_ev  = 1'b0;
		fault_set = 1'b0;
		fault_clr = 1'b0;
		rdw      = 16'h0000;
		rdb      = 8'h00;
		slew     = 4'h0;
		stp      = 6'h00;
		nc       = '0;
		st_nxt   = st_r;
		// first flop feeds only the second; edges use the later copies
		st_nxt.scl_s = {st_r.scl_s[1:0], LINK.scl};
		st_nxt.sda_s = {st_r.sda_s[1:0], LINK.sda};
		scl_rise = st_r.scl_s[1] & ~st_r.scl_s[2];
		scl_fall = ~st_r.scl_s[1] & st_r.scl_s[2];
		start_ev = st_r.scl_s[1] & st_r.scl_s[2] & st_r.sda_s[2] & ~st_r.sda_s[1];
		stop_ev  = st_r.scl_s[1] & st_r.scl_s[2] & ~st_r.sda_s[2] & st_r.sda_s[1];

		case (st_r.cmd)
			CMD_PAGE:  rdw = {14'h0000, st_r.page};
			CMD_OPER:  rdw = {8'h00, st_r.op[st_r.page]};
			CMD_FAULT: rdw = {8'h00, 6'h00, st_r.fault, 1'b0};
			CMD_REV:   rdw = {8'h00, PMB_REV};
			CMD_FCFG:  rdw = st_r.fcfg[st_r.page];
			CMD_MHI:   rdw = {{(16-CODE_W){1'b0}}, st_r.mhi[st_r.page]};
			CMD_MLO:   rdw = {{(16-CODE_W){1'b0}}, st_r.mlo[st_r.page]};
			CMD_IFCFG: rdw = {15'h0000, st_r.en};
			default:   rdw = 16'h0000;
		endcase
		rdb = (st_r.bidx == 2'h0) ? rdw[7:0] : ((st_r.bidx == 2'h1) ? rdw[15:8] : 8'h00);

		// ------------------------------------------------------------
		// link framing
		// ------------------------------------------------------------
		if (start_ev)
		begin
			st_nxt.ph     = DP_ADDR;
			st_nxt.bitn   = 4'h0;
			st_nxt.ackph  = 1'b0;
			st_nxt.sda_oe = 1'b0;
		end
		else if (stop_ev)
		begin
			st_nxt.ph     = DP_IDLE;
			st_nxt.ackph  = 1'b0;
			st_nxt.sda_oe = 1'b0;
			// writes land at the stop, so a group packet updates all targets together
			if (st_r.pend)
			begin
				st_nxt.pend = 1'b0;
				case (st_r.cmd)
					CMD_PAGE:  st_nxt.page = st_r.wbuf[1:0];
					CMD_OPER:  st_nxt.op[st_r.page] = st_r.wbuf[7:0];
					CMD_FAULT: fault_clr = st_r.wbuf[FAULT_BIT];
					CMD_FCFG:  st_nxt.fcfg[st_r.page] = st_r.wbuf;
					CMD_MHI:   st_nxt.mhi[st_r.page] = st_r.wbuf[CODE_W-1:0];
					CMD_MLO:   st_nxt.mlo[st_r.page] = st_r.wbuf[CODE_W-1:0];
					CMD_IFCFG: st_nxt.en = st_r.wbuf[IFCFG_EN_BIT];
					default:   ;
				endcase
			end
		end
		else if (scl_rise && st_r.ph != DP_IDLE)
		begin
			if (st_r.bitn < 4'h8)
			begin
				if (st_r.ph != DP_RD)
					st_nxt.sh = {st_r.sh[6:0], st_r.sda_s[1]};
				st_nxt.bitn = st_r.bitn + 4'h1;
			end
			else if (st_r.ph == DP_RD && st_r.ackph && st_r.sda_s[1])
				st_nxt.ph = DP_IDLE;
		end
		else if (scl_fall && (st_r.ph != DP_IDLE || st_r.ackph))
		begin
			if (st_r.ackph)
			begin
				st_nxt.ackph  = 1'b0;
				st_nxt.bitn   = 4'h0;
				st_nxt.sda_oe = (st_r.ph == DP_RD) & ~rdb[7];
			end
			else if (st_r.bitn == 4'h8)
			begin
				st_nxt.ackph  = 1'b1;
				st_nxt.sda_oe = 1'b0;
				case (st_r.ph)
					DP_ADDR:
					begin
						if (st_r.sh[7:1] == DEV_ADDR)
						begin
							st_nxt.sda_oe = 1'b1;
							st_nxt.ph     = st_r.sh[0] ? DP_RD : DP_CMD;
							st_nxt.bidx   = 2'h0;
						end
						else
							st_nxt.ph = DP_IDLE;
					end
					DP_CMD:
					begin
						if ((st_r.en || st_r.sh == CMD_IFCFG) && known(st_r.sh))
						begin
							st_nxt.sda_oe = 1'b1;
							st_nxt.cmd    = st_r.sh;
							st_nxt.ph     = DP_WR;
							st_nxt.bidx   = 2'h0;
							st_nxt.wbuf   = 16'h0000;
							st_nxt.pend   = 1'b0;
						end
						else
						begin
							fault_set = st_r.en;
							st_nxt.ph = DP_IDLE;
						end
					end
					DP_WR:
					begin
						st_nxt.sda_oe = 1'b1;
						st_nxt.pend   = 1'b1;
						if (st_r.bidx == 2'h0)
							st_nxt.wbuf[7:0] = st_r.sh;
						else if (st_r.bidx == 2'h1)
							st_nxt.wbuf[15:8] = st_r.sh;
						if (st_r.bidx != 2'h3)
							st_nxt.bidx = st_r.bidx + 2'h1;
					end
					DP_RD:   st_nxt.bidx = st_r.bidx + 2'h1;
					default: st_nxt.ph = DP_IDLE;
				endcase
			end
			else if (st_r.ph == DP_RD && st_r.bitn != 4'h0)
				st_nxt.sda_oe = ~rdb[3'h7 - st_r.bitn[2:0]];
		end

		// a clock held low too long abandons the packet and flags a fault
		if (st_r.ph != DP_IDLE && !st_r.scl_s[1])
		begin
			if (st_r.tmo == TW'(TIMEOUT_CYC - 1))
			begin
				fault_set     = 1'b1;
				st_nxt.ph     = DP_IDLE;
				st_nxt.ackph  = 1'b0;
				st_nxt.sda_oe = 1'b0;
				st_nxt.tmo    = '0;
			end
			else
				st_nxt.tmo = st_r.tmo + TW'(1);
		end
		else
			st_nxt.tmo = '0;
		st_nxt.fault = (st_r.fault & ~fault_clr) | fault_set;

		// ------------------------------------------------------------
		// per-channel sequencers
		// ------------------------------------------------------------
		for (int i = 0; i < NCH; i++)
		begin
			slew = st_r.fcfg[i][FC_SLEW_LSB +: 4];
			stp  = STEP_LSB[st_r.fcfg[i][FC_STEP_LSB +: 3]];
			if (slew == 4'h0)
				st_nxt.cnt[i] = 18'h00000;
			else if (st_r.cnt[i] == 18'h00000)
				st_nxt.cnt[i] = per_cyc(slew);
			else
				st_nxt.cnt[i] = st_r.cnt[i] - 18'h00001;
			st_nxt.oen[i] = (st_r.op[i] != OP_OFF);
			if (slew == 4'h0 || st_r.cnt[i] == 18'h00000)
			begin
				case (st_r.op[i])
					OP_MLO:
						st_nxt.code[i] = (st_r.code[i] < st_r.mlo[i]) ? step_up(st_r.code[i], stp, st_r.mlo[i]) :
							step_dn(st_r.code[i], stp, st_r.mlo[i]);
					OP_MHI:
						st_nxt.code[i] = (st_r.code[i] < st_r.mhi[i]) ? step_up(st_r.code[i], stp, st_r.mhi[i]) :
							step_dn(st_r.code[i], stp, st_r.mhi[i]);
					OP_ON:
					begin
						if (st_r.fcfg[i][FC_FUNC_BIT])
						begin
							case (st_r.fcfg[i][FC_WAVE_LSB +: 3])
								WAVE_TRI:
								begin
									if (st_r.up[i])
									begin
										nc = step_up(st_r.code[i], stp, st_r.mhi[i]);
										st_nxt.up[i] = (nc != st_r.mhi[i]);
									end
									else
									begin
										nc = step_dn(st_r.code[i], stp, st_r.mlo[i]);
										st_nxt.up[i] = (nc == st_r.mlo[i]);
									end
									st_nxt.code[i] = nc;
								end
								WAVE_SAW:
									st_nxt.code[i] = (st_r.code[i] >= st_r.mhi[i]) ? st_r.mlo[i] :
										step_up(st_r.code[i], stp, st_r.mhi[i]);
								WAVE_ISAW:
									st_nxt.code[i] = (st_r.code[i] <= st_r.mlo[i]) ? st_r.mhi[i] :
										step_dn(st_r.code[i], stp, st_r.mlo[i]);
								WAVE_SINE:
								begin
									st_nxt.code[i] = SINE_TAB[st_r.sidx[i]];
									st_nxt.sidx[i] = (st_r.sidx[i] == 5'(SINE_LEN - 1)) ? 5'h00 : st_r.sidx[i] + 5'h01;
								end
								default: ;
							endcase
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_IN)
	begin
		if (RST_IN)
		begin
			st_r       <= '0;
			st_r.scl_s <= 3'h7;
			st_r.sda_s <= 3'h7;
			st_r.ph    <= DP_IDLE;
			st_r.op    <= {NCH{RST_OP}};
			st_r.fcfg  <= {NCH{RST_FCFG}};
			st_r.mhi   <= {NCH{RST_MHI}};
			st_r.mlo   <= {NCH{RST_MLO}};
			st_r.up    <= {NCH{1'b1}};
		end
		else
			st_r <= st_nxt;
	end

	assign LINK.dev_sda_oe = st_r.sda_oe;
	assign CODE_OUT        = st_r.code;
	assign OUT_EN_OUT      = st_r.oen;
	assign FAULT_OUT       = st_r.fault;

endmodule: dsw_dev

/* File: verilog/dsw_host.sv */
`timescale 1ns/1ps
module dsw_host
	import dsw_pkg::*;
#(
	parameter int unsigned QTR_CYC = SCL_QTR_CYC // clock cycles per quarter link bit
)(
	input  wire logic        CLOCK_IN,            // 40 MHz clock
	input  wire logic        RST_IN,              // sync reset, active high
	input  wire logic [3:0]  AVS_ADDRESS_IN,      // byte address
	input  wire logic        AVS_READ_IN,         // read request
	input  wire logic        AVS_WRITE_IN,        // write request
	input  wire logic [31:0] AVS_WRITEDATA_IN,    // write data
	output logic      [31:0] AVS_READDATA_OUT,    // read data
	output logic             AVS_WAITREQUEST_OUT, // low for the accepting cycle
	dsw_link_if.host         LINK                 // two-wire link
);

	typedef struct packed {
		logic [7:0]  qc;
		logic [1:0]  q;
		dsw_hph_t    ph;
		logic [3:0]  bitn;
		logic [1:0]  k;
		logic [1:0]  rem;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic [15:0] wsh;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [6:0]  tgt;
		logic [7:0]  cmdc;
		logic [1:0]  nb;
		logic        rd;
		logic        rdph;
		logic        busy;
		logic        nack;
		logic        scl;
		logic        sda_oe;
		logic [1:0]  sda_s;
		logic        wait_r;
		logic [31:0] rdd;
	} dsw_host_st_t;

	dsw_host_st_t st_r;
	dsw_host_st_t st_nxt;

	always_comb
	begin
		logic       recv;
		logic [1:0] bi;
		logic       req;
		recv   = st_r.rdph && (st_r.k == 2'h2);
		bi     = st_r.nb - st_r.rem;
		req    = AVS_READ_IN | AVS_WRITE_IN;
		st_nxt = st_r;
		st_nxt.sda_s = {st_r.sda_s[0], LINK.sda};

		// ------------------------------------------------------------
		// register slave: one wait cycle, accepted while waitrequest low
		// ------------------------------------------------------------
		st_nxt.wait_r = ~(req & st_r.wait_r);
		if (req && st_r.wait_r)
		begin
			case (AVS_ADDRESS_IN)
				AV_CTRL:  st_nxt.rdd = {11'h000, st_r.rd, 2'h0, st_r.nb, st_r.cmdc, 1'b0, st_r.tgt};
				AV_WDATA: st_nxt.rdd = {16'h0000, st_r.wdata};
				AV_RDATA: st_nxt.rdd = {16'h0000, st_r.rdata};
				AV_STAT:  st_nxt.rdd = {30'h00000000, st_r.nack, st_r.busy};
				default:  st_nxt.rdd = 32'h00000000;
			endcase
		end
		if (AVS_WRITE_IN && !st_r.wait_r)
		begin
			if (AVS_ADDRESS_IN == AV_WDATA)
				st_nxt.wdata = AVS_WRITEDATA_IN[15:0];
			else if (AVS_ADDRESS_IN == AV_CTRL && !st_r.busy)
			begin
				st_nxt.tgt  = AVS_WRITEDATA_IN[CT_ADDR_LSB +: 7];
				st_nxt.cmdc = AVS_WRITEDATA_IN[CT_CMD_LSB +: 8];
				st_nxt.nb   = AVS_WRITEDATA_IN[CT_NB_LSB +: 2];
				st_nxt.rd   = AVS_WRITEDATA_IN[CT_RD_BIT];
				st_nxt.rem  = AVS_WRITEDATA_IN[CT_NB_LSB +: 2];
				st_nxt.wsh  = st_r.wdata;
				st_nxt.tx   = {AVS_WRITEDATA_IN[CT_ADDR_LSB +: 7], 1'b0};
				st_nxt.busy = 1'b1;
				st_nxt.nack = 1'b0;
				st_nxt.rdph = 1'b0;
				st_nxt.k    = 2'h0;
				st_nxt.q    = 2'h0;
				st_nxt.qc   = 8'h00;
				st_nxt.ph   = HP_START;
			end
		end

		// ------------------------------------------------------------
		// bit engine: four quarters per bit, link clock made here
		// ------------------------------------------------------------
		if (st_r.busy)
		begin
			st_nxt.qc = (st_r.qc == 8'(QTR_CYC - 1)) ? 8'h00 : st_r.qc + 8'h01;
			if (st_r.qc == 8'(QTR_CYC - 1))
			begin
				st_nxt.q = st_r.q + 2'h1;
				case (st_r.ph)
					HP_START:
						case (st_r.q)
							2'h0:    st_nxt.sda_oe = 1'b0;
							2'h1:    st_nxt.scl = 1'b1;
							2'h2:    st_nxt.sda_oe = 1'b1;
							default:
							begin
								st_nxt.scl  = 1'b0;
								st_nxt.ph   = HP_BYTE;
								st_nxt.bitn = 4'h0;
							end
						endcase
					HP_BYTE:
						case (st_r.q)
							2'h0:
								if (st_r.bitn < 4'h8)
									st_nxt.sda_oe = ~recv & ~st_r.tx[7];
								else
									st_nxt.sda_oe = recv && (st_r.rem > 2'h1);
							2'h1: st_nxt.scl = 1'b1;
							2'h2:
								if (st_r.bitn < 4'h8)
								begin
									st_nxt.tx = {st_r.tx[6:0], 1'b0};
									st_nxt.rx = {st_r.rx[6:0], st_r.sda_s[1]};
								end
								else if (!recv)
									st_nxt.nack = st_r.nack | st_r.sda_s[1];
							default:
							begin
								st_nxt.scl  = 1'b0;
								st_nxt.bitn = st_r.bitn + 4'h1;
								if (st_r.bitn == 4'h8)
								begin
									st_nxt.bitn = 4'h0;
									if (st_r.nack)
										st_nxt.ph = HP_STOP;
									else if (recv)
									begin
										if (bi == 2'h0)
											st_nxt.rdata[7:0] = st_r.rx;
										else
											st_nxt.rdata[15:8] = st_r.rx;
										st_nxt.rem = st_r.rem - 2'h1;
										if (st_r.rem <= 2'h1)
											st_nxt.ph = HP_STOP;
									end
									else if (st_r.k == 2'h0)
									begin
										st_nxt.tx = st_r.cmdc;
										st_nxt.k  = 2'h1;
									end
									else if (st_r.k == 2'h1 && st_r.rd && !st_r.rdph)
									begin
										st_nxt.rdph = 1'b1;
										st_nxt.ph   = HP_START;
										st_nxt.tx   = {st_r.tgt, 1'b1};
									end
									else if (st_r.k == 2'h1 && st_r.rdph)
									begin
										st_nxt.k = 2'h2;
										if (st_r.rem == 2'h0)
											st_nxt.ph = HP_STOP;
									end
									else if (st_r.rem == 2'h0)
										st_nxt.ph = HP_STOP;
									else
									begin
										st_nxt.tx  = st_r.wsh[7:0];
										st_nxt.wsh = {8'h00, st_r.wsh[15:8]};
										st_nxt.rem = st_r.rem - 2'h1;
										st_nxt.k   = 2'h2;
									end
								end
							end
						endcase
					HP_STOP:
						case (st_r.q)
							2'h0:    st_nxt.sda_oe = 1'b1;
							2'h1:    st_nxt.scl = 1'b1;
							2'h2:    st_nxt.sda_oe = 1'b0;
							default:
							begin
								st_nxt.ph   = HP_IDLE;
								st_nxt.busy = 1'b0;
							end
						endcase
					default: st_nxt.ph = HP_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (RST_IN)
		begin
			st_r        <= '0;
			st_r.ph     <= HP_IDLE;
			st_r.scl    <= 1'b1;
			st_r.sda_s  <= 2'h3;
			st_r.wait_r <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign LINK.scl            = st_r.scl;
	assign LINK.host_sda_oe    = st_r.sda_oe;
	assign AVS_READDATA_OUT    = st_r.rdd;
	assign AVS_WAITREQUEST_OUT = st_r.wait_r;

endmodule: dsw_host

/* File: test/dsw_asserts.sv */
`timescale 1ns/1ps
module dsw_asserts (
	input wire logic CLOCK_IN,    // clock
	input wire logic RST_IN,      // sync reset
	input wire logic scl,         // link clock
	input wire logic host_sda_oe, // host pulls data
	input wire logic dev_sda_oe,  // device pulls data
	input wire logic sda          // resolved data
);
	// ----------------------------------------------------------------
	// link wire rules, quarter bit of 8 clocks assumed
	// ----------------------------------------------------------------
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);
	AST_WIRE_AND: assert property (sda == !(host_sda_oe | dev_sda_oe))
		else $error("data line level wrong");
	AST_IDLE_RST: assert property ($fell(RST_IN) |-> scl && !host_sda_oe && !dev_sda_oe)
		else $error("link not idle after reset");
	AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
		else $error("link clock high too short");
	AST_SCL_LOW: assert property ($fell(scl) |=> !scl [*7])
		else $error("link clock low too short");
	AST_SCL_LOW_MAX: assert property ($fell(scl) |-> ##[1:64] scl)
		else $error("link clock held low");
	AST_DEV_ON_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device changed data with clock high");
	AST_DEV_AFTER_FALL: assert property ($rose(dev_sda_oe) |-> $past(scl, 8))
		else $error("device drove data without a clock fall");
	AST_HOST_MID_HIGH: assert property ($changed(host_sda_oe) && scl |-> $past(scl, 4))
		else $error("host data moved at clock rise");
	cover property ($rose(dev_sda_oe));
	cover property (scl && $rose(host_sda_oe));
	cover property (scl && $fell(host_sda_oe));
endmodule: dsw_asserts

/* File: test/dsw_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module dsw_bench;
	import dsw_pkg::*;
	localparam logic [6:0] DA = 7'h4a;
	localparam logic [2:0] WV [4] = '{WAVE_SAW, WAVE_TRI, WAVE_ISAW, WAVE_SINE};
	localparam logic [11:0] CA [4] = '{12'h015, 12'h015, 12'h010, 12'he66};
	localparam logic [11:0] CB [4] = '{12'h010, 12'h013, 12'h015, 12'he2f};
	logic                           clk = 1'b0;
	logic                           rst = 1'b1;
	logic                           rd = 1'b0;
	logic                           wr = 1'b0;
	logic [3:0]                     adr = 4'h0;
	logic [31:0]                    wd = 32'h0;
	wire logic [31:0]               av_rdata;
	wire logic                      av_wait;
	wire logic [NCH-1:0][CODE_W-1:0] code;
	wire logic [NCH-1:0]            oen;
	wire logic                      fault;
	int                             miscompares = 0;
	int                             total_checks = 0;
	dsw_link_if dsw_link_if_i ();
	dsw_dev #(.DEV_ADDR(DA), .TIMEOUT_CYC(2000), .TIME_SCALE(40)) dsw_dev_i (.CLOCK_IN(clk), .RST_IN(rst),
		.LINK(dsw_link_if_i.dev), .CODE_OUT(code), .OUT_EN_OUT(oen), .FAULT_OUT(fault));
	dsw_host #(.QTR_CYC(8)) dsw_host_i (.CLOCK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(av_rdata),
		.AVS_WAITREQUEST_OUT(av_wait), .LINK(dsw_link_if_i.host));
	dsw_asserts dsw_asserts_i (.CLOCK_IN(clk), .RST_IN(rst), .scl(dsw_link_if_i.scl),
		.host_sda_oe(dsw_link_if_i.host_sda_oe), .dev_sda_oe(dsw_link_if_i.dev_sda_oe), .sda(dsw_link_if_i.sda));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// host register access and one link transfer
	// ----------------------------------------------------------------
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		@(posedge clk);
		while (av_wait !== 1'b0) @(posedge clk);
		r = av_rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask: av
	// nack is compared after busy drops; a poll count that runs out is a mismatch
	task automatic lk(input logic [6:0] ta, input logic [7:0] c, input logic r, input logic [15:0] d,
		input logic nk);
		logic [31:0] s;
		av(1'b1, AV_WDATA, {16'h0, d}, s);
		av(1'b1, AV_CTRL, {11'h0, r, 4'h2, c, 1'b0, ta}, s);
		s = 32'h1;
		for (int i = 0; i < 5000 && s[0]; i++) av(1'b0, AV_STAT, 32'h0, s);
		`CHK(s[0], 1'b0)
		`CHK(s[1], nk)
	endtask: lk
	task final_report;
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask: final_report
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] q;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		lk(DA, CMD_OPER, 1'b0, {8'h0, OP_ON}, 1'b1);
		lk(DA, CMD_IFCFG, 1'b0, 16'h0001, 1'b0);
		lk(DA, CMD_REV, 1'b1, 16'h0, 1'b0);
		av(1'b0, AV_RDATA, 32'h0, q);
		`CHK(q[15:0], {8'h00, PMB_REV})
		lk(DA ^ 7'h01, CMD_OPER, 1'b0, {8'h0, OP_ON}, 1'b1);
		for (int p = 0; p < NCH; p++)
		begin
			lk(DA, CMD_PAGE, 1'b0, 16'(p), 1'b0);
			lk(DA, CMD_FCFG, 1'b0, {4'h0, 1'b1, WV[p], 8'h10}, 1'b0);
			lk(DA, CMD_MHI, 1'b0, 16'h0015, 1'b0);
			lk(DA, CMD_MLO, 1'b0, 16'h0010, 1'b0);
			lk(DA, CMD_OPER, 1'b0, {8'h0, OP_ON}, 1'b0);
		end
		`CHK(oen, 4'hf)
		// each channel must pass its marker code, then show the next code one clock later
		for (int p = 0; p < NCH; p++)
		begin
			for (int i = 0; i < 400 && code[p] !== CA[p]; i++) @(posedge clk);
			`CHK(code[p], CA[p])
			@(posedge clk);
			`CHK(code[p], CB[p])
		end
		lk(DA, 8'h55, 1'b0, 16'h0, 1'b1);
		`CHK(fault, 1'b1)
		lk(DA, CMD_FAULT, 1'b0, 16'h0002, 1'b0);
		`CHK(fault, 1'b0)
		// channel 0 slews to each limit at one code per 18 clocks and stops there
		lk(DA, CMD_PAGE, 1'b0, 16'h0000, 1'b0);
		lk(DA, CMD_FCFG, 1'b0, 16'h0004, 1'b0);
		lk(DA, CMD_OPER, 1'b0, {8'h0, OP_MLO}, 1'b0);
		for (int i = 0; i < 400 && code[0] !== 12'h010; i++) @(posedge clk);
		`CHK(code[0], 12'h010)
		lk(DA, CMD_OPER, 1'b0, {8'h0, OP_MHI}, 1'b0);
		for (int i = 0; i < 400 && code[0] !== 12'h012; i++) @(posedge clk);
		repeat (17) @(posedge clk);
		`CHK(code[0], 12'h012)
		@(posedge clk);
		`CHK(code[0], 12'h013)
		repeat (80) @(posedge clk);
		`CHK(code[0], 12'h015)
		final_report();
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		miscompares++;
		final_report();
	end
endmodule: dsw_bench
